// ---- oms_consts.svh ----
`ifndef OMS_CONSTS_SVH
`define OMS_CONSTS_SVH
// ***********************************************************
// timing
// ***********************************************************
`define OMS_CLK_MHZ        200
`define OMS_RAMP_UNIT_US   1000
`define OMS_RAMP_UNIT_CYC  (`OMS_RAMP_UNIT_US * `OMS_CLK_MHZ)
`define OMS_TENTH_US       100000
`define OMS_TENTH_CYC      (`OMS_TENTH_US * `OMS_CLK_MHZ)
`define OMS_FRAME_LAST     4'h9
`define OMS_FLASH_OFF_END  4'h1
`define OMS_HALF_ON_END    4'h5
// ***********************************************************
// register offsets
// ***********************************************************
`define OMS_ADR_CTRL       8'h00
`define OMS_ADR_CONFIG     8'h04
`define OMS_ADR_MANUAL     8'h08
`define OMS_ADR_SAFETY     8'h0c
`define OMS_ADR_SERIAL     8'h10
`define OMS_ADR_FLOAT      8'h14
`define OMS_ADR_STATUS     8'h18
`define OMS_ADR_Y          8'h1c
// ***********************************************************
// fields and reset values
// ***********************************************************
`define OMS_CFG_PRIO       0
`define OMS_CFG_SRC        1
`define OMS_CFG_SER        3:2
`define OMS_CFG_STRUCT     5:4
`define OMS_CFG_LOCK       7:6
`define OMS_RST_CONFIG     8'h00
`define OMS_RST_FLOAT      16'h003c
`define OMS_RST_VALUE      16'h0000
`define OMS_Y_MIN          16'hff9c
`define OMS_Y_MAX          16'h044c
`define OMS_Y_HALF         16'h01f4
`define OMS_IN_BLK_UP      0
`define OMS_IN_BLK_DN      1
`define OMS_IN_SAFE        2
`define OMS_IN_FOLLOW      3
`define OMS_IN_EXTMAN      4
`define OMS_IN_RAISE       5
`define OMS_IN_LOWER       6
`endif

// ---- oms_pkg.sv ----
// ***********************************************************
// types
// ***********************************************************
package oms_pkg;
   typedef enum logic [2:0] {
      MD_AUTO,
      MD_MANUAL,
      MD_FOLLOW,
      MD_SAFETY,
      MD_BLOCK
   } oms_mode_t;
   typedef logic signed [15:0] oms_val_t;
endpackage

// ---- oms_output_mode_selector.sv ----
// Functional notes
// - automatic value drives output when no other mode input or selection is set, and in the unblocked direction with one blocking input
// - manual is entered by front selection OR external manual request
// - manual needs safety and blocking off, and follow off when follow wins
// - manual value absolute for continuous, increment for step controllers
// - follow needs safety and blocking off, and manual off when manual wins
// - follow source: analog or incremental below level 2, serial value at 2 and 3
// - incremental follow value ramps full scale per floating time
// - step controllers with internal feedback use only the incremental follow value
// - safety input with no blocking routes safety value limited to 110 percent
// - step internal feedback safety: lower below 50 percent, raise otherwise
// - one blocking input freezes its direction, both freeze output fully
// - blocking over safety over manual/follow over automatic, switch orders manual/follow
// - manual lamp on when requested, flashes 0.1 off 0.9 on for external only
// - external lamp steady in follow, flashes 1:1 when manual holds it off
// - external manual request falling with no front selection returns to automatic
// - manual and incremental follow values track the output while inactive so switching is bumpless
// - follow stays prepared under manual and takes over when manual releases
// - lock setting forces front selection to automatic only or manual only
`timescale 1ns/100ps
`default_nettype none
`include "oms_consts.svh"
module oms_output_mode_selector
   import oms_pkg::*;
#(
   parameter int unsigned RAMP_UNIT_CYC = `OMS_RAMP_UNIT_CYC,
   parameter int unsigned TENTH_CYC     = `OMS_TENTH_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output var  logic [31:0] wb_dat_o,
   output var  logic        wb_ack_o,
   input  wire logic [1:0]  direction_block_inputs_i,
   input  wire logic        safety_request_i,
   input  wire logic        follow_request_i,
   input  wire logic        external_manual_request_i,
   input  wire logic        follow_raise_i,
   input  wire logic        follow_lower_i,
   input  wire logic [15:0] automatic_value_i,
   input  wire logic [15:0] analog_follow_value_i,
   output var  logic [15:0] y_o,
   output var  logic [2:0]  mode_o,
   output var  logic        manual_msg_o,
   output var  logic        follow_msg_o,
   output var  logic        step_raise_o,
   output var  logic        step_lower_o,
   output var  logic        manual_lamp_o,
   output var  logic        external_lamp_o
);
   // *********************************************************
   // helpers
   // *********************************************************
   localparam logic [17:0] RAMP_LAST  = 18'(RAMP_UNIT_CYC - 1);
   localparam logic [24:0] TENTH_LAST = 25'(TENTH_CYC - 1);
   function automatic oms_val_t clamp(input oms_val_t v);
      if (v < $signed(`OMS_Y_MIN)) begin
         return $signed(`OMS_Y_MIN);
      end
      if (v > $signed(`OMS_Y_MAX)) begin
         return $signed(`OMS_Y_MAX);
      end
      return v;
   endfunction
   function automatic logic [15:0] wmerge(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel);
      logic [15:0] r;
      r = old;
      if (sel[0]) begin
         r[7:0] = dat[7:0];
      end
      if (sel[1]) begin
         r[15:8] = dat[15:8];
      end
      return r;
   endfunction
   // *********************************************************
   // state
   // *********************************************************
   logic [6:0]  in_meta;
   logic [6:0]  in_sync;
   logic        ack;
   logic [31:0] dat;
   logic        front;
   logic [7:0]  cfg;
   oms_val_t    manual_val;
   oms_val_t    safety_val;
   oms_val_t    serial_val;
   logic [15:0] float_time;
   oms_val_t    ext_inc;
   oms_val_t    y;
   oms_mode_t   mode;
   logic        raise;
   logic        lower;
   logic        mlamp;
   logic        elamp;
   logic [24:0] tenth_cnt;
   logic [3:0]  tenth;
   logic [17:0] ramp_cnt;
   logic [15:0] ms_cnt;
   logic        next_ack;
   logic [31:0] next_dat;
   logic        next_front;
   logic [7:0]  next_cfg;
   oms_val_t    next_manual_val;
   oms_val_t    next_safety_val;
   oms_val_t    next_serial_val;
   logic [15:0] next_float_time;
   oms_val_t    next_ext_inc;
   oms_val_t    next_y;
   oms_mode_t   next_mode;
   oms_mode_t   mode_nb;
   logic        next_raise;
   logic        next_lower;
   logic        next_mlamp;
   logic        next_elamp;
   logic [24:0] next_tenth_cnt;
   logic [3:0]  next_tenth;
   logic [17:0] next_ramp_cnt;
   logic [15:0] next_ms_cnt;
   logic [1:0]  blk;
   logic        safe;
   logic        fol;
   logic        ext;
   logic        fe;
   logic        man_req;
   logic        prio;
   logic        step_int;
   logic        hit;
   logic        wr;
   logic        unit_step;
   oms_val_t    auto_c;
   oms_val_t    fsel;
   oms_val_t    cand;
   // *********************************************************
   // next-state logic
   // *********************************************************
   always_comb begin
      blk      = in_sync[`OMS_IN_BLK_DN:`OMS_IN_BLK_UP];
      safe     = in_sync[`OMS_IN_SAFE];
      fol      = in_sync[`OMS_IN_FOLLOW];
      ext      = in_sync[`OMS_IN_EXTMAN];
      prio     = cfg[`OMS_CFG_PRIO];
      step_int = (cfg[`OMS_CFG_STRUCT] == 2'h1);
      // lock overrides the front key only, other modes stay usable
      case (cfg[`OMS_CFG_LOCK])
         2'h1:    fe = 1'b0;
         2'h2:    fe = 1'b1;
         default: fe = front;
      endcase
      man_req = fe | ext;
      auto_c  = clamp(automatic_value_i);
      // priority chain, blocking decided separately below
      if (safe) begin
         mode_nb = MD_SAFETY;
      end else if (prio && man_req) begin
         mode_nb = MD_MANUAL;
      end else if (fol) begin
         mode_nb = MD_FOLLOW;
      end else if (man_req) begin
         mode_nb = MD_MANUAL;
      end else begin
         mode_nb = MD_AUTO;
      end
      next_mode = (|blk) ? MD_BLOCK : mode_nb;
      if (step_int) begin
         fsel = ext_inc;
      end else if (cfg[`OMS_CFG_SER] >= 2'h2) begin
         fsel = serial_val;
      end else if (cfg[`OMS_CFG_SRC]) begin
         fsel = ext_inc;
      end else begin
         fsel = clamp(analog_follow_value_i);
      end

      case (mode_nb)
         MD_MANUAL: cand = manual_val;
         MD_FOLLOW: cand = fsel;
         MD_SAFETY: cand = safety_val;
         default:   cand = auto_c;
      endcase

      // a blocked direction only lets the output move the other way
      case (blk)
         2'h3:    next_y = y;
         2'h1:    next_y = (cand < y) ? cand : y;
         2'h2:    next_y = (cand > y) ? cand : y;
         default: next_y = cand;
      endcase

      next_raise = (next_mode == MD_SAFETY) && step_int &&
                   (safety_val >= $signed(`OMS_Y_HALF));
      next_lower = (next_mode == MD_SAFETY) && step_int &&
                   (safety_val < $signed(`OMS_Y_HALF));
      // ramp prescaler: one value unit per floating-time milliseconds
      next_ramp_cnt = (ramp_cnt == RAMP_LAST) ? 18'h00000 : ramp_cnt + 18'h00001;
      next_ms_cnt   = ms_cnt;
      unit_step     = 1'b0;
      if (ramp_cnt == RAMP_LAST) begin
         if (ms_cnt + 16'h0001 >= float_time) begin
            next_ms_cnt = 16'h0000;
            unit_step   = 1'b1;
         end else begin
            next_ms_cnt = ms_cnt + 16'h0001;
         end
      end

      // tenth tick and ten-tenth frame for the lamps
      next_tenth_cnt = (tenth_cnt == TENTH_LAST) ? 25'h0000000 : tenth_cnt + 25'h0000001;
      next_tenth     = tenth;
      if (tenth_cnt == TENTH_LAST) begin
         next_tenth = (tenth == `OMS_FRAME_LAST) ? 4'h0 : tenth + 4'h1;
      end
      next_mlamp = man_req && (fe || tenth >= `OMS_FLASH_OFF_END);
      next_elamp = fol && (!(prio && man_req) || tenth < `OMS_HALF_ON_END);
      // bus slave: ack one cycle after the strobe, write on the ack edge
      hit             = wb_cyc_i && wb_stb_i;
      wr              = hit && ack && wb_we_i;
      next_ack        = hit && !ack;
      next_dat        = dat;
      next_front      = front;
      next_cfg        = cfg;
      next_safety_val = safety_val;
      next_serial_val = serial_val;
      next_float_time = float_time;
      next_manual_val = manual_val;
      if (hit && !ack) begin
         case (wb_adr_i)
            `OMS_ADR_CTRL:   next_dat = {31'h00000000, front};
            `OMS_ADR_CONFIG: next_dat = {24'h000000, cfg};
            `OMS_ADR_MANUAL: next_dat = {16'h0000, manual_val};
            `OMS_ADR_SAFETY: next_dat = {16'h0000, safety_val};
            `OMS_ADR_SERIAL: next_dat = {16'h0000, serial_val};
            `OMS_ADR_FLOAT:  next_dat = {16'h0000, float_time};
            `OMS_ADR_STATUS: next_dat = {22'h000000, elamp, mlamp, lower, raise,
                                         follow_msg_o, manual_msg_o, 1'b0, mode};
            `OMS_ADR_Y:      next_dat = {16'h0000, y};
            default:         next_dat = 32'h00000000;
         endcase
      end
      if (wr && wb_adr_i == `OMS_ADR_CTRL && wb_sel_i[0]) begin
         next_front = wb_dat_i[0];
      end
      if (wr && wb_adr_i == `OMS_ADR_CONFIG && wb_sel_i[0]) begin
         next_cfg = wb_dat_i[7:0];
      end
      if (wr && wb_adr_i == `OMS_ADR_SAFETY) begin
         next_safety_val = clamp(wmerge(safety_val, wb_dat_i, wb_sel_i));
      end
      if (wr && wb_adr_i == `OMS_ADR_SERIAL) begin
         next_serial_val = clamp(wmerge(serial_val, wb_dat_i, wb_sel_i));
      end
      if (wr && wb_adr_i == `OMS_ADR_FLOAT) begin
         next_float_time = wmerge(float_time, wb_dat_i, wb_sel_i);
      end
      // manual value: absolute or increment, else it shadows the output
      if (next_mode != MD_MANUAL) begin
         next_manual_val = next_y;
      end else if (wr && wb_adr_i == `OMS_ADR_MANUAL) begin
         if (cfg[`OMS_CFG_STRUCT] == 2'h0) begin
            next_manual_val = clamp(wmerge(manual_val, wb_dat_i, wb_sel_i));
         end else begin
            next_manual_val = clamp(manual_val + wmerge(16'h0000, wb_dat_i, wb_sel_i));
         end
      end

      // incremental follow value ramps while active, tracks output otherwise
      next_ext_inc = ext_inc;
      if (next_mode != MD_FOLLOW) begin
         next_ext_inc = next_y;
      end else if (unit_step && in_sync[`OMS_IN_RAISE] && !in_sync[`OMS_IN_LOWER]) begin
         next_ext_inc = clamp(ext_inc + 16'sh0001);
      end else if (unit_step && in_sync[`OMS_IN_LOWER] && !in_sync[`OMS_IN_RAISE]) begin
         next_ext_inc = clamp(ext_inc - 16'sh0001);
      end
   end

   // *********************************************************
   // registers
   // *********************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         in_meta         <= 7'h00;
         in_sync         <= 7'h00;
         ack             <= 1'b0;
         dat             <= 32'h00000000;
         front           <= 1'b0;
         cfg             <= `OMS_RST_CONFIG;
         manual_val      <= `OMS_RST_VALUE;
         safety_val      <= `OMS_RST_VALUE;
         serial_val      <= `OMS_RST_VALUE;
         float_time      <= `OMS_RST_FLOAT;
         ext_inc         <= `OMS_RST_VALUE;
         y               <= `OMS_RST_VALUE;
         mode            <= MD_AUTO;
         raise           <= 1'b0;
         lower           <= 1'b0;
         mlamp           <= 1'b0;
         elamp           <= 1'b0;
         tenth_cnt       <= 25'h0000000;
         tenth           <= 4'h0;
         ramp_cnt        <= 18'h00000;
         ms_cnt          <= 16'h0000;
         manual_msg_o    <= 1'b0;
         follow_msg_o    <= 1'b0;
      end else begin
         in_meta         <= {follow_lower_i, follow_raise_i, external_manual_request_i,
                             follow_request_i, safety_request_i, direction_block_inputs_i};
         in_sync         <= in_meta;
         ack             <= next_ack;
         dat             <= next_dat;
         front           <= next_front;
         cfg             <= next_cfg;
         manual_val      <= next_manual_val;
         safety_val      <= next_safety_val;
         serial_val      <= next_serial_val;
         float_time      <= next_float_time;
         ext_inc         <= next_ext_inc;
         y               <= next_y;
         mode            <= next_mode;
         raise           <= next_raise;
         lower           <= next_lower;
         mlamp           <= next_mlamp;
         elamp           <= next_elamp;
         tenth_cnt       <= next_tenth_cnt;
         tenth           <= next_tenth;
         ramp_cnt        <= next_ramp_cnt;
         ms_cnt          <= next_ms_cnt;
         manual_msg_o    <= (next_mode == MD_MANUAL);
         follow_msg_o    <= (next_mode == MD_FOLLOW);
      end
   end

   assign wb_ack_o        = ack;
   assign wb_dat_o        = dat;
   assign y_o             = y;
   assign mode_o          = mode;
   assign step_raise_o    = raise;
   assign step_lower_o    = lower;
   assign manual_lamp_o   = mlamp;
   assign external_lamp_o = elamp;

   // *********************************************************
   // assertions
   // *********************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_ext_release;
      ext && !fe ##1 !ext && !fe && !fol && !safe && blk == 2'h0;
   endsequence
   sequence s_flash_dark;
      man_req && !fe && tenth == 4'h0;
   endsequence
   AST_AUTO_ROUTE: assert property (
      (!man_req && !fol && !safe && blk == 2'h0) |=> (mode == MD_AUTO && y == $past(auto_c)))
      else $error("automatic value not routed");
   AST_MANUAL_ENTRY: assert property (
      (man_req && !safe && blk == 2'h0 && (prio || !fol)) |=> mode == MD_MANUAL)
      else $error("manual mode not entered");
   AST_FOLLOW_ENTRY: assert property (
      (fol && !safe && blk == 2'h0 && !(prio && man_req)) |=> mode == MD_FOLLOW)
      else $error("follow mode not entered");
   AST_SAFETY_VALUE: assert property (
      (safe && blk == 2'h0) |=> (mode == MD_SAFETY && y == $past(safety_val)
                                 && y <= $signed(`OMS_Y_MAX)))
      else $error("safety value not routed");
   // contacts follow the structure seen one cycle earlier, when they were computed
   AST_SAFETY_STEP: assert property (
      (mode == MD_SAFETY && $past(step_int)) |-> (raise != lower)
      && (raise == ($past(safety_val) >= $signed(`OMS_Y_HALF))))
      else $error("safety step direction wrong");
   AST_BLOCK_BOTH: assert property (
      (blk == 2'h3) |=> (mode == MD_BLOCK && y == $past(y)))
      else $error("output moved under full block");
   AST_BLOCK_UP: assert property (
      (blk == 2'h1) |=> (y <= $past(y)))
      else $error("output rose while raise blocked");
   AST_RETURN_AUTO: assert property (
      s_ext_release |=> mode == MD_AUTO)
      else $error("no return to automatic");
   AST_LAMP_FLASH: assert property (
      s_flash_dark ##1 man_req && !fe |-> !mlamp)
      else $error("manual lamp not dark in flash gap");
   AST_EXT_LAMP: assert property (
      (fol && !(prio && man_req)) [*2] |-> elamp)
      else $error("external lamp not steady");
endmodule
`default_nettype wire

// ---- oms_field_model.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "oms_consts.svh"
// ***********************************************************
// field pins and panel contacts
// ***********************************************************
// pins change only just after an edge, as a scanned panel would;
// they start low so no mode is requested while reset runs
module oms_field_model (
   input  wire logic       clk_i,
   input  wire logic [6:0] req_i,
   output var  logic [1:0] direction_block_inputs_o,
   output var  logic       safety_request_o,
   output var  logic       follow_request_o,
   output var  logic       external_manual_request_o,
   output var  logic       follow_raise_o,
   output var  logic       follow_lower_o
);
   logic [6:0] pins = 7'h00;
   always_ff @(posedge clk_i) begin
      pins <= req_i;
   end
   always_comb begin
      direction_block_inputs_o  = {pins[`OMS_IN_BLK_DN], pins[`OMS_IN_BLK_UP]};
      safety_request_o          = pins[`OMS_IN_SAFE];
      follow_request_o          = pins[`OMS_IN_FOLLOW];
      external_manual_request_o = pins[`OMS_IN_EXTMAN];
      follow_raise_o            = pins[`OMS_IN_RAISE];
      follow_lower_o            = pins[`OMS_IN_LOWER];
   end
endmodule
`default_nettype wire

// ---- tb_output_mode_selector.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "oms_consts.svh"
module tb_output_mode_selector;
   import oms_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc   = 1'b0;
   logic        stb   = 1'b0;
   logic        we    = 1'b0;
   logic [7:0]  adr   = 8'h00;
   logic [31:0] wdat  = 32'h0;
   logic [31:0] rd;
   logic [6:0]  req   = 7'h00;
   logic [15:0] av    = 16'h0000;
   logic [15:0] fv    = 16'h0000;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic [1:0]  blk;
   logic        safe, fol, extm, rai, low;
   logic [15:0] y_o;
   logic [2:0]  mode_o;
   logic        step_raise_o, step_lower_o, manual_lamp_o, external_lamp_o;
   logic        manual_msg_o, follow_msg_o;
   int          err_total = 0;
   int          total_checks = 0;
   int          seed = 75341;
   int          m, e;
   logic [15:0] a, b;

   initial forever #2.5 clk_i = ~clk_i;

   oms_field_model i_oms_field_model (
      .clk_i(clk_i), .req_i(req), .direction_block_inputs_o(blk),
      .safety_request_o(safe), .follow_request_o(fol),
      .external_manual_request_o(extm), .follow_raise_o(rai), .follow_lower_o(low));

   // short counts keep lamp frames and ramp steps within a brief run
   oms_output_mode_selector #(.RAMP_UNIT_CYC(10), .TENTH_CYC(20)) i_oms_output_mode_selector (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .direction_block_inputs_i(blk), .safety_request_i(safe),
      .follow_request_i(fol), .external_manual_request_i(extm), .follow_raise_i(rai),
      .follow_lower_i(low), .automatic_value_i(av), .analog_follow_value_i(fv),
      .y_o(y_o), .mode_o(mode_o), .manual_msg_o(manual_msg_o), .follow_msg_o(follow_msg_o),
      .step_raise_o(step_raise_o), .step_lower_o(step_lower_o),
      .manual_lamp_o(manual_lamp_o), .external_lamp_o(external_lamp_o));

   // ***********************************************************
   // helpers
   // ***********************************************************
   task automatic complete_run();
      if (err_total == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      total_checks++;
      if (g !== x) begin
         err_total++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   // the wait has no limit of its own: a missing ack is caught by the watchdog
   task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= ad;
      wdat <= d;
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] ad, input logic [31:0] x);
      wb(1'b0, ad, 32'h0);
      chk(rd, x);
   endtask
   task automatic drive(input logic [6:0] r);
      @(posedge clk_i);
      req <= r;
   endtask
   task automatic setv(input logic [15:0] x, input logic [15:0] f);
      @(posedge clk_i);
      av <= x;
      fv <= f;
   endtask
   // pins pass two sync stages and a register before the mode settles
   task automatic seem(input oms_mode_t md, input logic [15:0] y);
      repeat (8) @(posedge clk_i);
      chk({29'h0, mode_o}, 32'(md));
      chk({16'h0, y_o}, {16'h0, y});
      chk({30'h0, manual_msg_o, follow_msg_o}, {30'h0, md == MD_MANUAL, md == MD_FOLLOW});
   endtask
   // one frame is ten tenths of 20 cycles, so 200 samples cover any phase
   task automatic lamps(output int mc, output int ec);
      mc = 0;
      ec = 0;
      repeat (200) begin
         @(posedge clk_i);
         mc += int'(manual_lamp_o === 1'b1);
         ec += int'(external_lamp_o === 1'b1);
      end
   endtask
   function automatic logic [15:0] rv();
      return 16'(($random(seed) & 1023) - 100);
   endfunction
   function automatic logic [15:0] lim(input int v);
      return 16'(v < -100 ? -100 : (v > 1100 ? 1100 : v));
   endfunction

   // ***********************************************************
   // main sequence
   // ***********************************************************
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      rdchk(`OMS_ADR_FLOAT, {16'h0, `OMS_RST_FLOAT});
      rdchk(`OMS_ADR_CONFIG, 32'h0);
      rdchk(`OMS_ADR_STATUS, 32'h0);
      rdchk(8'h20, 32'h0);
      wb(1'b1, `OMS_ADR_Y, 32'h1234);
      rdchk(`OMS_ADR_Y, 32'h0);
      for (m = 0; m < 4; m++) begin
         a = rv();
         setv(a, fv);
         seem(MD_AUTO, a);
      end
      wb(1'b1, `OMS_ADR_CTRL, 32'h1);
      seem(MD_MANUAL, a);
      b = rv();
      wb(1'b1, `OMS_ADR_MANUAL, {16'h0, b});
      seem(MD_MANUAL, b);
      lamps(m, e);
      chk(m, 200);
      wb(1'b1, `OMS_ADR_CTRL, 32'h0);
      seem(MD_AUTO, a);
      drive(7'h10);
      seem(MD_MANUAL, a);
      lamps(m, e);
      chk(m, 180);
      drive(7'h00);
      seem(MD_AUTO, a);
      b = rv();
      setv(a, b);
      drive(7'h18);
      seem(MD_FOLLOW, b);
      lamps(m, e);
      chk(e, 200);
      wb(1'b1, `OMS_ADR_CONFIG, 32'h1);
      seem(MD_MANUAL, b);
      lamps(m, e);
      chk(e, 100);
      b = rv();
      setv(a, b);
      drive(7'h08);
      seem(MD_FOLLOW, b);
      wb(1'b1, `OMS_ADR_CONFIG, 32'h08);
      b = rv();
      wb(1'b1, `OMS_ADR_SERIAL, {16'h0, b});
      seem(MD_FOLLOW, b);
      drive(7'h00);
      wb(1'b1, `OMS_ADR_FLOAT, 32'h1);
      wb(1'b1, `OMS_ADR_CONFIG, 32'h02);
      drive(7'h08);
      seem(MD_FOLLOW, a);
      drive(7'h28);
      repeat (200) @(posedge clk_i);
      drive(7'h08);
      repeat (8) @(posedge clk_i);
      m = int'($signed(y_o)) - int'($signed(a));
      chk(32'(m >= 18 && m <= 21), 32'h1);
      b = y_o;
      wb(1'b1, `OMS_ADR_CONFIG, 32'h10);
      setv(a, rv());
      seem(MD_FOLLOW, b);
      drive(7'h04);
      wb(1'b1, `OMS_ADR_SAFETY, 32'd400);
      seem(MD_SAFETY, 16'd400);
      chk({30'h0, step_raise_o, step_lower_o}, 32'h1);
      wb(1'b1, `OMS_ADR_SAFETY, 32'd500);
      seem(MD_SAFETY, 16'd500);
      chk({30'h0, step_raise_o, step_lower_o}, 32'h2);
      wb(1'b1, `OMS_ADR_SAFETY, 32'd1500);
      seem(MD_SAFETY, lim(1500));
      wb(1'b1, `OMS_ADR_CONFIG, 32'h0);
      drive(7'h07);
      seem(MD_BLOCK, lim(1500));
      drive(7'h03);
      seem(MD_BLOCK, lim(1500));
      drive(7'h01);
      seem(MD_BLOCK, a);
      setv(16'(a + 16'd50), fv);
      seem(MD_BLOCK, a);
      drive(7'h02);
      seem(MD_BLOCK, 16'(a + 16'd50));
      drive(7'h00);
      wb(1'b1, `OMS_ADR_CONFIG, 32'h40);
      wb(1'b1, `OMS_ADR_CTRL, 32'h1);
      seem(MD_AUTO, 16'(a + 16'd50));
      wb(1'b1, `OMS_ADR_CONFIG, 32'h80);
      wb(1'b1, `OMS_ADR_CTRL, 32'h0);
      seem(MD_MANUAL, 16'(a + 16'd50));
      wb(1'b1, `OMS_ADR_CONFIG, 32'ha0);
      b = rv();
      wb(1'b1, `OMS_ADR_MANUAL, {16'h0, b});
      seem(MD_MANUAL, lim(int'($signed(a)) + 50 + int'($signed(b))));
      wb(1'b0, `OMS_ADR_STATUS, 32'h0);
      chk(rd & 32'h3f, 32'h11);
      complete_run();
   end

   // a hang shows up as a mismatch verdict; cut it off well past the run
   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      complete_run();
   end
endmodule
`default_nettype wire
